//--- hw/output_switch_control.sv
// protection and drive logic for two high and two low output switches
`timescale 1ns/1ps
`default_nettype none
`include "output_switch_regs.svh"
module output_switch_control
  import output_switch_pkg::*;
#(
  parameter int SWITCHES = 2
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic high_switch_control_wr,
  input  wire logic [3:0] high_switch_control_data,
  input  wire logic low_switch_control_wr,
  input  wire logic [3:0] low_switch_control_data,
  input  wire logic overvoltage_shutdown_enable,
  input  wire logic high_switch_irq_mask,
  input  wire logic low_switch_irq_mask,
  input  wire logic interrupt_source_rd,
  input  wire logic low_power_mode,
  input  wire logic cyclic_sense_window,
  input  wire logic direct_pwm_input,
  input  wire logic high_switch_overtemp,
  input  wire logic low_switch_overtemp,
  input  wire logic high_voltage,
  input  wire logic [1:0] high_switch_open_load_bits,
  input  wire logic [1:0] high_switch_current_limit_bits,
  input  wire logic [1:0] low_switch_open_load_bits,
  input  wire logic [1:0] low_switch_current_limit_bits,
  output logic [1:0] high_switch_drive,
  output logic [1:0] low_switch_drive,
  output logic [3:0] high_switch_status,
  output logic [3:0] low_switch_status,
  output logic [3:0] high_switch_control,
  output logic [3:0] low_switch_control,
  output logic [1:0] interrupt_source,
  output logic irq_n
);

  // the register layout is fixed at two switches a side
  if (SWITCHES != 2) begin : g_bad_width
    $error("output_switch_control serves exactly two switches a side");
  end

  localparam int PIN_W = 12;

  // pin inputs: two flops before any logic looks at them
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] meta_r;
  logic [PIN_W-1:0] meta_nxt;
  logic [PIN_W-1:0] pin_r;
  logic [PIN_W-1:0] pin_nxt;

  assign pin_raw = {direct_pwm_input, high_voltage,
                    low_switch_overtemp, high_switch_overtemp,
                    low_switch_current_limit_bits,
                    low_switch_open_load_bits,
                    high_switch_current_limit_bits,
                    high_switch_open_load_bits};

  always_comb begin
    meta_nxt = pin_raw;
    pin_nxt  = meta_r;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= '0;
      pin_r  <= '0;
    end else begin
      meta_r <= meta_nxt;
      pin_r  <= pin_nxt;
    end
  end

  // synchronised views, indexed by side_t
  pair_t ol_s [2];
  pair_t cl_s [2];
  logic  ot_s [2];
  logic  hv_s;
  logic  pwm_s;
  logic  hv_trip;

  assign ol_s[HIGH_SIDE] = pin_r[1:0];
  assign cl_s[HIGH_SIDE] = pin_r[3:2];
  assign ol_s[LOW_SIDE]  = pin_r[5:4];
  assign cl_s[LOW_SIDE]  = pin_r[7:6];
  assign ot_s[HIGH_SIDE] = pin_r[8];
  assign ot_s[LOW_SIDE]  = pin_r[9];
  assign hv_s            = pin_r[10];
  assign pwm_s           = pin_r[11];
  assign hv_trip         = overvoltage_shutdown_enable & hv_s;

  // per-side views of the control ports
  logic    wr   [2];
  nibble_t wdat [2];
  logic    mask [2];
  logic    gate [2];

  assign wr[HIGH_SIDE]   = high_switch_control_wr;
  assign wr[LOW_SIDE]    = low_switch_control_wr;
  assign wdat[HIGH_SIDE] = high_switch_control_data;
  assign wdat[LOW_SIDE]  = low_switch_control_data;
  assign mask[HIGH_SIDE] = high_switch_irq_mask;
  assign mask[LOW_SIDE]  = low_switch_irq_mask;
  // high side survives low power only inside a cyclic sense window
  assign gate[HIGH_SIDE] = low_power_mode & ~cyclic_sense_window;
  assign gate[LOW_SIDE]  = low_power_mode;

  // switch on: enable alone, or enable and pin when pwm is selected
  function automatic logic sw_on(input logic en, input logic sel,
                                 input logic pwm);
    sw_on = en & (~sel | pwm);
  endfunction

  // status nibble: two open-load, two limit, one open-load, one limit
  function automatic nibble_t stat_pack(input pair_t ol, input pair_t cl);
    stat_pack = {ol[1], cl[1], ol[0], cl[0]};
  endfunction

  // per-side state
  nibble_t ctrl_r   [2];
  nibble_t ctrl_nxt [2];
  logic    ot_r     [2];
  logic    ot_nxt   [2];
  logic    hv_r     [2];
  logic    hv_nxt   [2];
  logic    src_r    [2];
  logic    src_nxt  [2];
  pair_t   drv_r    [2];
  pair_t   drv_nxt  [2];
  nibble_t stat_r   [2];
  nibble_t stat_nxt [2];
  logic    off      [2];
  logic    irq_n_r;
  logic    irq_n_nxt;

  always_comb begin
    irq_n_nxt = 1'b1;
    for (int s = 0; s < 2; s++) begin
      ctrl_nxt[s] = wr[s] ? wdat[s] : ctrl_r[s];
      // set wins: a write during the fault never clears the latch
      if (ot_s[s]) begin
        ot_nxt[s] = 1'b1;
      end else if (wr[s]) begin
        ot_nxt[s] = 1'b0;
      end else begin
        ot_nxt[s] = ot_r[s];
      end
      if (hv_trip) begin
        hv_nxt[s] = 1'b1;
      end else if (wr[s] && !hv_s) begin
        hv_nxt[s] = 1'b0;
      end else begin
        hv_nxt[s] = hv_r[s];
      end
      // source flag: an event in the read cycle is kept
      if (ot_s[s]) begin
        src_nxt[s] = 1'b1;
      end else if (interrupt_source_rd) begin
        src_nxt[s] = 1'b0;
      end else begin
        src_nxt[s] = src_r[s];
      end
      // live fault terms too, so the switch drops with the fault edge
      off[s] = ot_r[s] | hv_r[s] | ot_s[s] | hv_trip;
      for (int i = 0; i < 2; i++) begin
        drv_nxt[s][i] = sw_on(ctrl_r[s][i], ctrl_r[s][i+2], pwm_s)
                        & ~off[s] & ~gate[s];
      end
      stat_nxt[s] = stat_pack(ol_s[s], cl_s[s]);
      if (irq_n_nxt && src_nxt[s] && mask[s]) begin
        irq_n_nxt = 1'b0;
      end
    end
    if (ot_r[HIGH_SIDE]) begin
      stat_nxt[HIGH_SIDE] = `STAT_THERMAL;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int s = 0; s < 2; s++) begin
        ctrl_r[s] <= `CTRL_RESET;
        ot_r[s]   <= 1'b0;
        hv_r[s]   <= 1'b0;
        src_r[s]  <= 1'b0;
        drv_r[s]  <= 2'h0;
        stat_r[s] <= `STAT_RESET;
      end
      irq_n_r <= 1'b1;
    end else begin
      for (int s = 0; s < 2; s++) begin
        ctrl_r[s] <= ctrl_nxt[s];
        ot_r[s]   <= ot_nxt[s];
        hv_r[s]   <= hv_nxt[s];
        src_r[s]  <= src_nxt[s];
        drv_r[s]  <= drv_nxt[s];
        stat_r[s] <= stat_nxt[s];
      end
      irq_n_r <= irq_n_nxt;
    end
  end

  assign high_switch_drive   = drv_r[HIGH_SIDE];
  assign low_switch_drive    = drv_r[LOW_SIDE];
  assign high_switch_status  = stat_r[HIGH_SIDE];
  assign low_switch_status   = stat_r[LOW_SIDE];
  assign high_switch_control = ctrl_r[HIGH_SIDE];
  assign low_switch_control  = ctrl_r[LOW_SIDE];
  assign interrupt_source    = {src_r[LOW_SIDE], src_r[HIGH_SIDE]};
  assign irq_n               = irq_n_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  hs_enable_off_a: assert property (
    !ctrl_r[HIGH_SIDE][`CTRL_EN1_BIT] |=> !high_switch_drive[0])
    else $error("high switch one on without enable");
  hs_plain_on_a: assert property (
    ctrl_r[HIGH_SIDE][`CTRL_EN2_BIT] && !ctrl_r[HIGH_SIDE][`CTRL_PWM2_BIT]
    && !off[HIGH_SIDE] && !gate[HIGH_SIDE] |=> high_switch_drive[1])
    else $error("high switch two off with plain enable");
  hs_pwm_follow_a: assert property (
    ctrl_r[HIGH_SIDE][`CTRL_EN1_BIT] && ctrl_r[HIGH_SIDE][`CTRL_PWM1_BIT]
    && !off[HIGH_SIDE] && !gate[HIGH_SIDE]
    |=> high_switch_drive[0] == $past(pwm_s))
    else $error("high switch one not following pwm pin");
  hs_status_a: assert property (
    !ot_r[HIGH_SIDE] |=> high_switch_status ==
      {$past(ol_s[HIGH_SIDE][1]), $past(cl_s[HIGH_SIDE][1]),
       $past(ol_s[HIGH_SIDE][0]), $past(cl_s[HIGH_SIDE][0])})
    else $error("high status not tracking the load sense");
  hs_ot_shut_a: assert property (
    ot_s[HIGH_SIDE] |=> high_switch_drive == 2'h0
      && interrupt_source[0] ##1 high_switch_status == `STAT_THERMAL)
    else $error("high overtemperature not shut down and flagged");
  hs_thermal_a: assert property (
    ot_r[HIGH_SIDE] |=> high_switch_status == `STAT_THERMAL)
    else $error("high thermal shutdown not shown in status");
  irq_masked_a: assert property (
    !high_switch_irq_mask && !low_switch_irq_mask |=> irq_n)
    else $error("interrupt driven while both masks clear");
  hs_rearm_a: assert property (
    ot_r[HIGH_SIDE] && high_switch_control_wr && !ot_s[HIGH_SIDE]
    |=> !ot_r[HIGH_SIDE])
    else $error("high control write did not re-arm");
  hs_stay_off_a: assert property (
    ot_r[HIGH_SIDE] && !high_switch_control_wr |=> ot_r[HIGH_SIDE]
      ##0 high_switch_drive == 2'h0)
    else $error("high switches left shutdown without a write");
  hv_off_a: assert property (
    hv_trip |=> high_switch_drive == 2'h0 && low_switch_drive == 2'h0
      && hv_r[HIGH_SIDE] && hv_r[LOW_SIDE])
    else $error("overvoltage shutdown missed");
  hs_cyclic_a: assert property (
    low_power_mode && cyclic_sense_window && !off[HIGH_SIDE]
    && ctrl_r[HIGH_SIDE][`CTRL_EN1_BIT]
    && !ctrl_r[HIGH_SIDE][`CTRL_PWM1_BIT] |=> high_switch_drive[0])
    else $error("high switch blocked during cyclic sense");
  ls_enable_off_a: assert property (
    !ctrl_r[LOW_SIDE][`CTRL_EN2_BIT] |=> !low_switch_drive[1])
    else $error("low switch two on without enable");
  ls_pwm_follow_a: assert property (
    ctrl_r[LOW_SIDE][`CTRL_EN2_BIT] && ctrl_r[LOW_SIDE][`CTRL_PWM2_BIT]
    && !off[LOW_SIDE] && !low_power_mode
    |=> low_switch_drive[1] == $past(pwm_s))
    else $error("low switch two not following pwm pin");
  ls_status_a: assert property (
    1'b1 |=> low_switch_status ==
      {$past(ol_s[LOW_SIDE][1]), $past(cl_s[LOW_SIDE][1]),
       $past(ol_s[LOW_SIDE][0]), $past(cl_s[LOW_SIDE][0])})
    else $error("low status not tracking the load sense");
  ls_ot_shut_a: assert property (
    ot_s[LOW_SIDE] |=> low_switch_drive == 2'h0 && interrupt_source[1])
    else $error("low overtemperature not shut down and flagged");
  ls_irq_a: assert property (
    src_nxt[LOW_SIDE] && low_switch_irq_mask |=> !irq_n)
    else $error("masked-in low shutdown gave no interrupt");
  ls_rearm_a: assert property (
    ot_r[LOW_SIDE] && low_switch_control_wr && !ot_s[LOW_SIDE]
    |=> !ot_r[LOW_SIDE])
    else $error("low control write did not re-arm");
  ls_sleep_a: assert property (
    low_power_mode |=> low_switch_drive == 2'h0)
    else $error("low switch on in low power mode");
  ctrl_write_a: assert property (
    high_switch_control_wr && low_switch_control_wr
    |=> high_switch_control == $past(high_switch_control_data)
      && low_switch_control == $past(low_switch_control_data))
    else $error("control write not stored");
  irq_ack_a: assert property (
    interrupt_source_rd && !ot_s[HIGH_SIDE] && !ot_s[LOW_SIDE]
    |=> irq_n && interrupt_source == 2'h0)
    else $error("interrupt not released by source read");

  hs_shutdown_c: cover property (
    ot_s[HIGH_SIDE] ##[1:20] high_switch_control_wr && !ot_s[HIGH_SIDE]);
  irq_cycle_c: cover property (!irq_n ##[1:20] interrupt_source_rd);
  pwm_toggle_c: cover property (
    ctrl_r[LOW_SIDE][`CTRL_PWM2_BIT] && $rose(low_switch_drive[1]));
  hv_shutdown_c: cover property (hv_trip ##[1:20] !hv_s);

endmodule // output_switch_control
`default_nettype wire

//--- hw/output_switch_pkg.sv
// types shared by the output switch control block
package output_switch_pkg;
  typedef logic [3:0] nibble_t;
  typedef enum logic { HIGH_SIDE, LOW_SIDE } side_t;
  typedef logic [1:0] pair_t;
endpackage

//--- hw/output_switch_regs.svh
// register layout and timing constants for the output switch control block
// Function
// - each high switch turns on or off by its own control enable bit
// - high switch with enable and pwm select set follows the pwm pin
// - high switch open-load status bit set while its current is too low
// - high switch current-limit status bit set while it is limiting
// - high overtemperature shuts both high switches, latches, flags source
// - high thermal shutdown shows all four high status bits set
// - high shutdown drives interrupt only while its mask bit is set
// - high switches stay off until a control write after fault clears
// - overvoltage with shutdown enabled turns high switches off until rewrite
// - high switches still work in sleep or stop for cyclic sensing
// - each low switch turns on or off by its own control enable bit
// - low switch with enable and pwm select set follows the pwm pin
// - low switch open-load status bit set while its current is too low
// - low switch current-limit status bit set while it is limiting
// - low overtemperature shuts both low switches, latches, flags source
// - low shutdown drives interrupt only while its mask bit is set
// - low switches stay off until a control write after fault clears
// - overvoltage with shutdown enabled turns low switches off until rewrite
// - low switches forced off in sleep or stop mode
// - high control register at 6: pwm selects bits 3,2, enables 1,0
// - low control register at 8: pwm selects bits 3,2, enables 1,0
// - high status: two open-load, two limit, one open-load, one limit
// - interrupt line low until a source read acknowledges, then high
`ifndef OUTPUT_SWITCH_REGS_SVH
`define OUTPUT_SWITCH_REGS_SVH
`define HIGH_SWITCH_CONTROL_ADDR 4'h6
`define HIGH_SWITCH_STATUS_ADDR  4'h7
`define LOW_SWITCH_CONTROL_ADDR  4'h8
`define CTRL_EN1_BIT   0
`define CTRL_EN2_BIT   1
`define CTRL_PWM1_BIT  2
`define CTRL_PWM2_BIT  3
`define STAT_CL1_BIT   0
`define STAT_OL1_BIT   1
`define STAT_CL2_BIT   2
`define STAT_OL2_BIT   3
`define CTRL_RESET     4'h0
`define STAT_RESET     4'h0
`define STAT_THERMAL   4'hF
`define SYNC_STAGES    2
`endif

//--- tb/switch_load_model.sv
// load model: resistive loads on one pair of output switches
`timescale 1ns/1ps
`default_nettype none
module switch_load_model (
  input  wire logic [1:0] drive,
  input  wire logic [1:0] open_cmd,
  input  wire logic [1:0] short_cmd,
  input  wire logic       hot_cmd,
  output logic      [1:0] open_load,
  output logic      [1:0] current_limit,
  output logic            overtemp
);
  // load current only flows while the switch is on, so open-load and limit show then
  assign open_load     = drive & open_cmd;
  assign current_limit = drive & short_cmd;
  assign overtemp      = hot_cmd;
endmodule // switch_load_model
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the output switch control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  import output_switch_pkg::*;
  logic ref_clk = 1'b0, sys_rst = 1'b1;
  logic h_wr = 1'b0, l_wr = 1'b0, hve = 1'b0, hm = 1'b1, lm = 1'b0;
  logic rd = 1'b0, lpm = 1'b0, csw = 1'b0, pwm = 1'b0, hv = 1'b0;
  logic h_hot = 1'b0, l_hot = 1'b0, h_ot, l_ot, irq_n;
  nibble_t h_d = 4'h0, l_d = 4'h0, h_st, l_st, h_ctl, l_ctl;
  pair_t h_open = 2'h0, h_short = 2'h0, l_open = 2'h0, l_short = 2'h0;
  pair_t h_ol, h_cl, l_ol, l_cl, h_drv, l_drv, src;
  int bad_count = 0, tests_run = 0;
  always #20 ref_clk = ~ref_clk;
  output_switch_control DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .high_switch_control_wr(h_wr), .high_switch_control_data(h_d),
    .low_switch_control_wr(l_wr), .low_switch_control_data(l_d),
    .overvoltage_shutdown_enable(hve), .high_switch_irq_mask(hm),
    .low_switch_irq_mask(lm), .interrupt_source_rd(rd),
    .low_power_mode(lpm), .cyclic_sense_window(csw),
    .direct_pwm_input(pwm), .high_switch_overtemp(h_ot),
    .low_switch_overtemp(l_ot), .high_voltage(hv),
    .high_switch_open_load_bits(h_ol),
    .high_switch_current_limit_bits(h_cl),
    .low_switch_open_load_bits(l_ol), .low_switch_current_limit_bits(l_cl),
    .high_switch_drive(h_drv), .low_switch_drive(l_drv),
    .high_switch_status(h_st), .low_switch_status(l_st),
    .high_switch_control(h_ctl), .low_switch_control(l_ctl),
    .interrupt_source(src), .irq_n(irq_n));
  switch_load_model high_load (.drive(h_drv), .open_cmd(h_open),
    .short_cmd(h_short), .hot_cmd(h_hot), .open_load(h_ol),
    .current_limit(h_cl), .overtemp(h_ot));
  switch_load_model low_load (.drive(l_drv), .open_cmd(l_open),
    .short_cmd(l_short), .hot_cmd(l_hot), .open_load(l_ol),
    .current_limit(l_cl), .overtemp(l_ot));
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // one strobe cycle; both sides may be written in the same cycle
  task automatic wr(input logic hw, input nibble_t hd,
                    input logic lw, input nibble_t ld);
    @(posedge ref_clk);
    h_wr <= hw;
    h_d  <= hd;
    l_wr <= lw;
    l_d  <= ld;
    @(posedge ref_clk);
    h_wr <= 1'b0;
    l_wr <= 1'b0;
    w(3);
  endtask
  task automatic ack();
    @(posedge ref_clk);
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    w(2);
  endtask
  task automatic done(input string name);
    $display("test %s done, mismatches so far %0d", name, bad_count);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    // whole run is about 155 cycles; 5000 leaves ample margin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    results();
  end
  initial begin
    nibble_t d;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    w(1);
    `CHK(h_drv, 2'h0)
    `CHK(irq_n, 1'b1)
    for (int i = 0; i < 4; i++) begin
      d = nibble_t'(i);
      wr(1'b1, d, 1'b1, d);
      `CHK(h_ctl, d)
      `CHK(l_ctl, d)
      `CHK(h_drv, d[1:0])
      `CHK(l_drv, d[1:0])
    end
    done("enables");
    wr(1'b1, 4'h7, 1'b1, 4'hB);
    pwm <= 1'b1;
    w(6);
    `CHK(h_drv, 2'h3)
    `CHK(l_drv, 2'h3)
    pwm <= 1'b0;
    w(6);
    `CHK(h_drv, 2'h2)
    `CHK(l_drv, 2'h1)
    wr(1'b1, 4'h3, 1'b1, 4'h3);
    done("pwm");
    h_open <= 2'h1;
    h_short <= 2'h2;
    l_open <= 2'h1;
    l_short <= 2'h2;
    w(6);
    `CHK(h_st, 4'h6)
    `CHK(l_st, 4'h6)
    h_open <= 2'h2;
    h_short <= 2'h1;
    w(6);
    `CHK(h_st, 4'h9)
    h_open <= 2'h0;
    h_short <= 2'h0;
    l_open <= 2'h0;
    l_short <= 2'h0;
    done("status");
    h_hot <= 1'b1;
    w(6);
    `CHK(h_drv, 2'h0)
    `CHK(src, 2'h1)
    `CHK(irq_n, 1'b0)
    `CHK(h_st, 4'hF)
    `CHK(l_drv, 2'h3)
    wr(1'b1, 4'h3, 1'b0, 4'h0);
    `CHK(h_drv, 2'h0)
    h_hot <= 1'b0;
    w(6);
    `CHK(h_drv, 2'h0)
    `CHK(irq_n, 1'b0)
    ack();
    `CHK(src, 2'h0)
    `CHK(irq_n, 1'b1)
    wr(1'b1, 4'h3, 1'b0, 4'h0);
    `CHK(h_drv, 2'h3)
    done("high thermal");
    hm <= 1'b0;
    l_hot <= 1'b1;
    w(6);
    `CHK(l_drv, 2'h0)
    `CHK(src, 2'h2)
    `CHK(irq_n, 1'b1)
    lm <= 1'b1;
    w(2);
    `CHK(irq_n, 1'b0)
    l_hot <= 1'b0;
    w(6);
    ack();
    `CHK(irq_n, 1'b1)
    wr(1'b0, 4'h0, 1'b1, 4'h3);
    `CHK(l_drv, 2'h3)
    done("low thermal");
    hv <= 1'b1;
    w(6);
    `CHK(h_drv, 2'h3)
    hve <= 1'b1;
    w(6);
    `CHK(h_drv, 2'h0)
    `CHK(l_drv, 2'h0)
    wr(1'b1, 4'h3, 1'b1, 4'h3);
    `CHK(h_drv, 2'h0)
    hv <= 1'b0;
    w(6);
    `CHK(l_drv, 2'h0)
    wr(1'b1, 4'h3, 1'b1, 4'h3);
    `CHK(h_drv, 2'h3)
    `CHK(l_drv, 2'h3)
    hve <= 1'b0;
    done("overvoltage");
    lpm <= 1'b1;
    w(4);
    `CHK(h_drv, 2'h0)
    `CHK(l_drv, 2'h0)
    csw <= 1'b1;
    w(4);
    `CHK(h_drv, 2'h3)
    `CHK(l_drv, 2'h0)
    lpm <= 1'b0;
    w(4);
    `CHK(l_drv, 2'h3)
    done("low power");
    results();
  end
endmodule // tb_top
`default_nettype wire
